// ==== pkg/ifeb_pkg.sv ====
`default_nettype none
package ifeb_pkg;
    // Register indices (byte addresses on the plain port)
    localparam logic [3:0] ADDR_CTRL_B = 4'h0;
    localparam logic [3:0] ADDR_CTRL_C = 4'h1;
    localparam logic [3:0] ADDR_CTRL_D = 4'h2;
    localparam logic [3:0] ADDR_HALL = 4'h3;
    localparam logic [3:0] ADDR_CAP_ADC = 4'h4;
    localparam logic [3:0] ADDR_PWM = 4'h5;
    localparam logic [3:0] ADDR_TMR2 = 4'h6;
    localparam logic [3:0] ADDR_TMR0 = 4'h7;
    localparam logic [3:0] ADDR_TMR1 = 4'h8;
    localparam logic [3:0] ADDR_TW_TMR3 = 4'h9;
    localparam logic [3:0] ADDR_SVC = 4'ha;
    localparam int NUM_GROUPS = 7;
    // Field positions
    localparam int FLAG_LSB = 4;
    localparam int EN_LSB = 0;
    localparam int FIELD_W = 4;
    // Implemented-bit masks of the group registers
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_HALL = 8'h77;
    localparam logic [7:0] MASK_TMR = 8'h33;
    localparam logic [7:0] MASK_TW = 8'h77;
    // Primary register bit positions
    localparam int B_OC_REQ = 7;
    localparam int B_LOW_REQ = 6;
    localparam int B_G1_REQ = 5;
    localparam int B_FILT_REQ = 4;
    localparam int D_TICK_REQ = 7;
    localparam int D_G6_REQ = 6;
    localparam int D_EE_REQ = 5;
    localparam int D_SER_REQ = 4;
    localparam logic [7:0] RESET_VAL = 8'h00;
endpackage
`default_nettype wire

// ==== hw/ifeb_group_reg.sv ====
`timescale 1ns/1ns
`default_nettype none
module ifeb_group_reg #(
    parameter logic [7:0] MASK = 8'hff
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [3:0] event_in,
    output logic [7:0] value_out,
    output logic pending_out
);
    logic [7:0] value;
    logic [3:0] ev;
    assign ev = event_in & MASK[ifeb_pkg::FLAG_LSB +: ifeb_pkg::FIELD_W];
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            value <= ifeb_pkg::RESET_VAL;
        end else if (wr_in) begin
            // Event beats a software clear in the same cycle
            value <= (wdata_in & MASK) | {ev, 4'h0};
        end else begin
            value <= value | {ev, 4'h0};
        end
    end
    assign value_out = value;
    // Source flag together with its own enable raises the group request
    assign pending_out = |(value[ifeb_pkg::FLAG_LSB +: ifeb_pkg::FIELD_W]
        & value[ifeb_pkg::EN_LSB +: ifeb_pkg::FIELD_W]);
endmodule
`default_nettype wire

// ==== hw/ifeb_bank.sv ====
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Control B: overcurrent flag bit 7, enable bit 3.
// - Control B: low-supply flag bit 6, enable bit 2.
// - Control B: group 1 flag/en bits 5/1, filtered input bits 4/0.
// - Control C: group 5..2 flags bits 7..4, enables 3..0.
// - Control D: tick, group 6, eeprom, serial flags 7..4, enables 3..0.
// - Serial enable gates its interrupt; flag stays readable either way.
// - Hall group: C,B,A flags 6..4, enables 2..0; bits 7,3 read 0.
// - Group source flags never self-clear; software writes 0.
// - Capture/ADC group: four flags 7..4, enables 3..0.
// - PWM group: period and three duty flags 7..4, enables 3..0.
// - Timer 2 group: A/P flags 5/4, enables 1/0, rest zero.
// - Timer 0 group: same layout as timer 2.
// - Timer 1 group: same layout as timer 2.
// - Last group: two-wire flag 6, timer 3 A/P 5/4, enables 2..0.
// - Flags set on events regardless of enable; enable gates interrupt, except hall enables, whose group pending reaches no request.
// - Servicing clears global enable; new requests still latch.
// - Servicing a group clears its group flag unless the group is still pending; source flags remain.
// - Any flag newly set requests wake-up from sleep or idle.
module ifeb_bank (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    input wire logic OC_EVENT_IN,
    input wire logic LOW_SUPPLY_EVENT_IN,
    input wire logic FILT_EVENT_IN,
    input wire logic TICK_EVENT_IN,
    input wire logic EEPROM_EVENT_IN,
    input wire logic SERIAL_EVENT_IN,
    input wire logic [2:0] HALL_EVENT_IN,
    input wire logic [3:0] CAP_ADC_EVENT_IN,
    input wire logic [3:0] PWM_EVENT_IN,
    input wire logic [1:0] TMR2_EVENT_IN,
    input wire logic [1:0] TMR0_EVENT_IN,
    input wire logic [1:0] TMR1_EVENT_IN,
    input wire logic [2:0] TW_TMR3_EVENT_IN,
    input wire logic SVC_IN,
    input wire logic [3:0] SVC_SRC_IN,
    input wire logic GLOBAL_IRQ_EN_IN,
    output logic [9:0] IRQ_REQ_OUT,
    output logic WAKE_OUT
);
    typedef enum logic [3:0] {
        SRC_FILT = 4'h0,
        SRC_G1 = 4'h1,
        SRC_LOW = 4'h2,
        SRC_OC = 4'h3,
        SRC_G2 = 4'h4,
        SRC_G3 = 4'h5,
        SRC_G4 = 4'h6,
        SRC_G5 = 4'h7,
        SRC_SER = 4'h8,
        SRC_EE = 4'h9,
        SRC_G6 = 4'ha,
        SRC_TICK = 4'hb
    } ifeb_src_t;

    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [7:0] ctrl_d;
    logic [7:0] grp_val [0:6];
    logic [6:0] grp_pend;
    logic [6:0] grp_wr;
    logic [3:0] grp_ev [0:6];
    logic [3:0] svc_src;
    logic svc_go;
    logic [7:0] next_ctrl_b;
    logic [7:0] next_ctrl_c;
    logic [7:0] next_ctrl_d;
    logic [7:0] next_rdata;
    logic [9:0] next_irq;
    logic [39:0] all_flags;
    logic [39:0] prev_flags;
    logic [7:0] clr_b;
    logic [7:0] clr_c;
    logic [7:0] clr_d;

    function automatic logic is_wr(input logic [3:0] a, input logic [3:0] target);
        is_wr = (a == target);
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] cur, input logic w,
        input logic [7:0] d, input logic [7:0] set, input logic [7:0] clr);
        logic [7:0] base;
        base = w ? d : cur;
        merge = (base & ~clr) | set;
    endfunction

    // Source event vectors, flags aligned to bits 3..0 of the flag field
    assign grp_ev[0] = {1'b0, HALL_EVENT_IN};
    assign grp_ev[1] = CAP_ADC_EVENT_IN;
    assign grp_ev[2] = PWM_EVENT_IN;
    assign grp_ev[3] = {2'b00, TMR2_EVENT_IN};
    assign grp_ev[4] = {2'b00, TMR0_EVENT_IN};
    assign grp_ev[5] = {2'b00, TMR1_EVENT_IN};
    assign grp_ev[6] = {1'b0, TW_TMR3_EVENT_IN};

    always_comb begin
        for (int i = 0; i < ifeb_pkg::NUM_GROUPS; i++) begin
            grp_wr[i] = WR_IN && is_wr(ADDR_IN, ifeb_pkg::ADDR_HALL + 4'(i));
        end
    end

    ifeb_group_reg #(.MASK(ifeb_pkg::MASK_HALL)) u_hall (
        .clk_in(CLK_IN), .rst_in(RST_IN), .wr_in(grp_wr[0]), .wdata_in(WDATA_IN),
        .event_in(grp_ev[0]), .value_out(grp_val[0]), .pending_out(grp_pend[0]));
    ifeb_group_reg #(.MASK(ifeb_pkg::MASK_FULL)) u_cap (
        .clk_in(CLK_IN), .rst_in(RST_IN), .wr_in(grp_wr[1]), .wdata_in(WDATA_IN),
        .event_in(grp_ev[1]), .value_out(grp_val[1]), .pending_out(grp_pend[1]));
    ifeb_group_reg #(.MASK(ifeb_pkg::MASK_FULL)) u_pwm (
        .clk_in(CLK_IN), .rst_in(RST_IN), .wr_in(grp_wr[2]), .wdata_in(WDATA_IN),
        .event_in(grp_ev[2]), .value_out(grp_val[2]), .pending_out(grp_pend[2]));
    ifeb_group_reg #(.MASK(ifeb_pkg::MASK_TMR)) u_tmr2 (
        .clk_in(CLK_IN), .rst_in(RST_IN), .wr_in(grp_wr[3]), .wdata_in(WDATA_IN),
        .event_in(grp_ev[3]), .value_out(grp_val[3]), .pending_out(grp_pend[3]));
    ifeb_group_reg #(.MASK(ifeb_pkg::MASK_TMR)) u_tmr0 (
        .clk_in(CLK_IN), .rst_in(RST_IN), .wr_in(grp_wr[4]), .wdata_in(WDATA_IN),
        .event_in(grp_ev[4]), .value_out(grp_val[4]), .pending_out(grp_pend[4]));
    ifeb_group_reg #(.MASK(ifeb_pkg::MASK_TMR)) u_tmr1 (
        .clk_in(CLK_IN), .rst_in(RST_IN), .wr_in(grp_wr[5]), .wdata_in(WDATA_IN),
        .event_in(grp_ev[5]), .value_out(grp_val[5]), .pending_out(grp_pend[5]));
    ifeb_group_reg #(.MASK(ifeb_pkg::MASK_TW)) u_tw (
        .clk_in(CLK_IN), .rst_in(RST_IN), .wr_in(grp_wr[6]), .wdata_in(WDATA_IN),
        .event_in(grp_ev[6]), .value_out(grp_val[6]), .pending_out(grp_pend[6]));

    // Service acknowledge clears only the serviced group flag, or the filtered input flag for SRC_FILT
    assign svc_go = SVC_IN;
    assign svc_src = SVC_SRC_IN;

    always_comb begin
        clr_b = 8'h00;
        clr_c = 8'h00;
        clr_d = 8'h00;
        if (svc_go) begin
            case (svc_src)
                SRC_G1: clr_b[ifeb_pkg::B_G1_REQ] = 1'b1;
                SRC_G2: clr_c[4] = 1'b1;
                SRC_G3: clr_c[5] = 1'b1;
                SRC_G4: clr_c[6] = 1'b1;
                SRC_G5: clr_c[7] = 1'b1;
                SRC_G6: clr_d[ifeb_pkg::D_G6_REQ] = 1'b1;
                SRC_FILT: clr_b[ifeb_pkg::B_FILT_REQ] = 1'b1;
                default: clr_b = 8'h00;
            endcase
        end
    end

    always_comb begin
        next_ctrl_b = merge(ctrl_b, WR_IN && is_wr(ADDR_IN, ifeb_pkg::ADDR_CTRL_B), WDATA_IN,
            {OC_EVENT_IN, LOW_SUPPLY_EVENT_IN, grp_pend[1], FILT_EVENT_IN, 4'h0},
            clr_b);
        next_ctrl_c = merge(ctrl_c, WR_IN && is_wr(ADDR_IN, ifeb_pkg::ADDR_CTRL_C), WDATA_IN,
            {grp_pend[5], grp_pend[4], grp_pend[3], grp_pend[2], 4'h0},
            clr_c);
        next_ctrl_d = merge(ctrl_d, WR_IN && is_wr(ADDR_IN, ifeb_pkg::ADDR_CTRL_D), WDATA_IN,
            {TICK_EVENT_IN, grp_pend[6], EEPROM_EVENT_IN, SERIAL_EVENT_IN, 4'h0},
            clr_d);
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            ctrl_b <= ifeb_pkg::RESET_VAL;
            ctrl_c <= ifeb_pkg::RESET_VAL;
            ctrl_d <= ifeb_pkg::RESET_VAL;
        end else begin
            ctrl_b <= next_ctrl_b;
            ctrl_c <= next_ctrl_c;
            ctrl_d <= next_ctrl_d;
        end
    end

    // Register read, data one cycle after the strobe
    always_comb begin
        next_rdata = 8'h00;
        if (ADDR_IN == ifeb_pkg::ADDR_CTRL_B) begin
            next_rdata = ctrl_b;
        end else if (ADDR_IN == ifeb_pkg::ADDR_CTRL_C) begin
            next_rdata = ctrl_c;
        end else if (ADDR_IN == ifeb_pkg::ADDR_CTRL_D) begin
            next_rdata = ctrl_d;
        end else if (ADDR_IN >= ifeb_pkg::ADDR_HALL && ADDR_IN <= ifeb_pkg::ADDR_TW_TMR3) begin
            next_rdata = grp_val[3'(ADDR_IN - ifeb_pkg::ADDR_HALL)];
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= 8'h00;
        end else if (RD_IN) begin
            RDATA_OUT <= next_rdata;
        end else begin
            RDATA_OUT <= 8'h00;
        end
    end

    // Per-source requests: flag and enable, gated by the core's global enable.
    // The core clears its global enable on service, which blocks new requests here.
    always_comb begin
        next_irq[0] = ctrl_b[ifeb_pkg::B_FILT_REQ] & ctrl_b[0];
        next_irq[1] = ctrl_b[ifeb_pkg::B_G1_REQ] & ctrl_b[1];
        next_irq[2] = ctrl_b[ifeb_pkg::B_LOW_REQ] & ctrl_b[2];
        next_irq[3] = ctrl_b[ifeb_pkg::B_OC_REQ] & ctrl_b[3];
        next_irq[4] = |(ctrl_c[7:4] & ctrl_c[3:0]);
        next_irq[5] = ctrl_d[ifeb_pkg::D_SER_REQ] & ctrl_d[0];
        next_irq[6] = ctrl_d[ifeb_pkg::D_EE_REQ] & ctrl_d[1];
        next_irq[7] = ctrl_d[ifeb_pkg::D_G6_REQ] & ctrl_d[2];
        next_irq[8] = ctrl_d[ifeb_pkg::D_TICK_REQ] & ctrl_d[3];
        next_irq[9] = 1'b0;
        if (!GLOBAL_IRQ_EN_IN) begin
            next_irq = 10'h000;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            IRQ_REQ_OUT <= 10'h000;
        end else begin
            IRQ_REQ_OUT <= next_irq;
        end
    end

    // Wake on a flag rising; a flag already set before sleep gives no wake
    assign all_flags = {ctrl_b[7:4], ctrl_c[7:4], ctrl_d[7:4],
        grp_val[0][7:4], grp_val[1][7:4], grp_val[2][7:4], grp_val[3][7:4],
        grp_val[4][7:4], grp_val[5][7:4], grp_val[6][7:4]};

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            prev_flags <= 40'h0;
            WAKE_OUT <= 1'b0;
        end else begin
            prev_flags <= all_flags;
            WAKE_OUT <= |(all_flags & ~prev_flags);
        end
    end
endmodule
`default_nettype wire

// ==== sim/ifeb_bank_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module ifeb_bank_chk (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic GLOBAL_IRQ_EN_IN,
    input wire logic [9:0] IRQ_REQ_OUT
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);
    sequence s_wr_rd(logic [3:0] a);
        WR_IN && ADDR_IN == a ##1 RD_IN && ADDR_IN == a;
    endsequence
    // Must judge cycles inside reset, so no disable here
    property p_rst_quiet;
        disable iff (1'b0) RST_IN |=> RDATA_OUT == 8'h00 && IRQ_REQ_OUT == 10'h000;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not cleared");
    property p_rd_window;
        RDATA_OUT != 8'h00 |-> $past(RD_IN);
    endproperty
    a_rd_window: assert property (p_rd_window) else $error("read data outside slot");
    property p_unmapped;
        RD_IN && ADDR_IN > 4'h9 |=> RDATA_OUT == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_hall_mask;
        RD_IN && ADDR_IN == ifeb_pkg::ADDR_HALL |=> (RDATA_OUT & ~ifeb_pkg::MASK_HALL) == 8'h00;
    endproperty
    a_hall_mask: assert property (p_hall_mask) else $error("hall spare bits set");
    property p_tmr_mask;
        RD_IN && ADDR_IN >= ifeb_pkg::ADDR_TMR2 && ADDR_IN <= ifeb_pkg::ADDR_TMR1
            |=> (RDATA_OUT & ~ifeb_pkg::MASK_TMR) == 8'h00;
    endproperty
    a_tmr_mask: assert property (p_tmr_mask) else $error("timer spare bits set");
    property p_tw_mask;
        RD_IN && ADDR_IN == ifeb_pkg::ADDR_TW_TMR3 |=> (RDATA_OUT & ~ifeb_pkg::MASK_TW) == 8'h00;
    endproperty
    a_tw_mask: assert property (p_tw_mask) else $error("last group spare bits set");
    property p_irq_gate;
        !GLOBAL_IRQ_EN_IN |=> IRQ_REQ_OUT == 10'h000;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request without global enable");
    property p_en_b;
        s_wr_rd(ifeb_pkg::ADDR_CTRL_B) |=> RDATA_OUT[3:0] == $past(WDATA_IN[3:0], 2);
    endproperty
    a_en_b: assert property (p_en_b) else $error("control b enables lost");
    property p_en_c;
        s_wr_rd(ifeb_pkg::ADDR_CTRL_C) |=> RDATA_OUT[3:0] == $past(WDATA_IN[3:0], 2);
    endproperty
    a_en_c: assert property (p_en_c) else $error("control c enables lost");
endmodule
`default_nettype wire

// ==== sim/ifeb_src_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ifeb_src_model (
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic [25:0] word_in,
    output logic oc_out,
    output logic low_out,
    output logic filt_out,
    output logic tick_out,
    output logic ee_out,
    output logic ser_out,
    output logic [2:0] hall_out,
    output logic [3:0] cap_out,
    output logic [3:0] pwm_out,
    output logic [1:0] tmr2_out,
    output logic [1:0] tmr0_out,
    output logic [1:0] tmr1_out,
    output logic [2:0] tw_out
);
    logic [25:0] stage1;
    logic [25:0] stage2;
    always_ff @(posedge clk_in) begin
        stage1 <= word_in;
        stage2 <= stage1;
    end
    // Events fire whatever the enables hold; slow path adds a cycle of lag
    assign {tw_out, tmr1_out, tmr0_out, tmr2_out, pwm_out, cap_out, hall_out, ser_out, ee_out,
        tick_out, filt_out, low_out, oc_out} = slow_in ? stage2 : stage1;
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0, rd = 1'b0, svc = 1'b0, glob = 1'b0, slow = 1'b0, rd_d = 1'b0, g;
    logic [3:0] svc_src = 4'h0;
    logic [25:0] word = 26'h0;
    logic [7:0] rdata;
    logic [9:0] irq;
    logic wake, oc, low, filt, tick, ee, ser;
    logic [2:0] hall, tw;
    logic [3:0] cap, pwm;
    logic [1:0] t2, t0, t1;
    logic [7:0] exp_q[$];
    logic [7:0] d[10];
    logic [7:0] e[3];
    int failures = 0, checks_done = 0, wake_cnt = 0, cyc = 0;
    always #5 clk = ~clk;
    ifeb_src_model SRC (.clk_in(clk), .slow_in(slow), .word_in(word), .oc_out(oc), .low_out(low),
        .filt_out(filt), .tick_out(tick), .ee_out(ee), .ser_out(ser), .hall_out(hall),
        .cap_out(cap), .pwm_out(pwm), .tmr2_out(t2), .tmr0_out(t0), .tmr1_out(t1), .tw_out(tw));
    ifeb_bank DUT (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .OC_EVENT_IN(oc), .LOW_SUPPLY_EVENT_IN(low),
        .FILT_EVENT_IN(filt), .TICK_EVENT_IN(tick), .EEPROM_EVENT_IN(ee), .SERIAL_EVENT_IN(ser),
        .HALL_EVENT_IN(hall), .CAP_ADC_EVENT_IN(cap), .PWM_EVENT_IN(pwm), .TMR2_EVENT_IN(t2),
        .TMR0_EVENT_IN(t0), .TMR1_EVENT_IN(t1), .TW_TMR3_EVENT_IN(tw), .SVC_IN(svc),
        .SVC_SRC_IN(svc_src), .GLOBAL_IRQ_EN_IN(glob), .IRQ_REQ_OUT(irq), .WAKE_OUT(wake));
    function automatic logic [7:0] mask(input int i);
        case (i)
            3: return ifeb_pkg::MASK_HALL;
            6, 7, 8: return ifeb_pkg::MASK_TMR;
            9: return ifeb_pkg::MASK_TW;
            default: return ifeb_pkg::MASK_FULL;
        endcase
    endfunction
    function automatic logic pend(input logic [7:0] v);
        return |(v[7:4] & v[3:0]);
    endfunction
    function automatic logic [9:0] irq_exp(input logic [7:0] b, c, x, input logic gl);
        logic [9:0] r;
        r = {1'b0, x[7] & x[3], x[6] & x[2], x[5] & x[1], x[4] & x[0], pend(c),
            b[7] & b[3], b[6] & b[2], b[5] & b[1], b[4] & b[0]};
        return gl ? r : 10'h000;
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, r, input logic [3:0] a, input logic [7:0] dt,
            input logic [25:0] ev);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= dt;
        word <= ev;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] ex);
        exp_q.push_back(ex);
        bus(1'b0, 1'b1, a, 8'h00, 26'h0);
    endtask
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] dt, input logic [7:0] ex);
        bus(1'b1, 1'b0, a, dt, 26'h0);
        rd_chk(a, ex);
    endtask
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00, 26'h0);
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= rd;
        cyc++;
        if (wake) wake_cnt++;
        if (rd_d) cmp(16'(rdata), 16'(exp_q.pop_front()));
        if (cyc == 3000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(32'h8018));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 16; i++) rd_chk(4'(i), 8'h00);
        repeat (20) begin
            g = 1'($urandom);
            glob <= g;
            for (int i = 3; i < 10; i++) begin
                d[i] = 8'($urandom);
                wr_rd(4'(i), d[i], d[i] & mask(i));
            end
            wr_rd(4'hf, 8'($urandom), 8'h00);
            for (int i = 0; i < 3; i++) d[i] = 8'($urandom);
            // Group pending follows only the bits the group register keeps
            for (int i = 3; i < 10; i++) d[i] = d[i] & mask(i);
            e[0] = d[0] | {2'b00, pend(d[4]), 5'h00};
            e[1] = d[1] | {pend(d[8]), pend(d[7]), pend(d[6]), pend(d[5]), 4'h0};
            e[2] = d[2] | {1'b0, pend(d[9]), 6'h00};
            for (int i = 0; i < 3; i++) wr_rd(4'(i), d[i], e[i]);
            idle(4);
            cmp(16'(irq), 16'(irq_exp(e[0], e[1], e[2], g)));
        end
        glob <= 1'b0;
        // Groups first, or their pending state would re-set the primary flags
        for (int i = 3; i < 13; i++) wr_rd(4'(i % 10), 8'h00, 8'h00);
        idle(3);
        wake_cnt = 0;
        bus(1'b0, 1'b0, 4'h0, 8'h00, 26'h3ffffff);
        idle(4);
        cmp(16'(wake_cnt > 0), 16'h1);
        for (int i = 0; i < 10; i++)
            rd_chk(4'(i), i == 0 ? 8'hd0 : i == 1 ? 8'h00 : i == 2 ? 8'hb0 : mask(i) & 8'hf0);
        slow <= 1'b1;
        wake_cnt = 0;
        bus(1'b0, 1'b0, 4'h0, 8'h00, 26'h3ffffff);
        idle(5);
        cmp(16'(wake_cnt), 16'h0);
        slow <= 1'b0;
        bus(1'b0, 1'b0, 4'h0, 8'h00, 26'h40);
        wr_rd(ifeb_pkg::ADDR_HALL, 8'h00, 8'h10);
        wr_rd(ifeb_pkg::ADDR_TMR0, 8'h00, 8'h00);
        wr_rd(ifeb_pkg::ADDR_CTRL_B, 8'hf2, 8'hf2);
        glob <= 1'b1;
        wr_rd(ifeb_pkg::ADDR_CTRL_D, 8'hb1, 8'hb1);
        idle(3);
        cmp(16'(irq), 16'h022);
        wr_rd(ifeb_pkg::ADDR_CTRL_D, 8'hb0, 8'hb0);
        idle(3);
        cmp(16'(irq), 16'h002);
        svc <= 1'b1;
        svc_src <= 4'h1;
        glob <= 1'b0;
        idle(1);
        svc <= 1'b0;
        idle(3);
        cmp(16'(irq), 16'h000);
        rd_chk(ifeb_pkg::ADDR_CTRL_B, 8'hd2);
        rd_chk(ifeb_pkg::ADDR_CAP_ADC, 8'hf0);
        idle(3);
        cmp(16'(exp_q.size()), 16'h0);
        finish_test();
    end
endmodule
bind ifeb_bank ifeb_bank_chk u_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .GLOBAL_IRQ_EN_IN(GLOBAL_IRQ_EN_IN), .IRQ_REQ_OUT(IRQ_REQ_OUT));
`default_nettype wire
